// [hdl/crms_chan.sv]
// One video channel: pin synchroniser, caption insertion and outputs
`timescale 1ns/1ps
`default_nettype none
module crms_chan (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire crms_pkg::crms_vid_t vid_pin,
  input wire crms_pkg::crms_text_t ins_text,
  input wire crms_pkg::crms_text_t bridge_text,
  input wire logic [crms_pkg::STD_W-1:0] bridge_std,
  output crms_pkg::crms_vid_t vid_sync,
  output crms_pkg::crms_vid_t out_main,
  output crms_pkg::crms_mon_t out_mon
);

  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  // Whole word is taken only once stages two and three agree
  crms_pkg::crms_vid_t s1_r;
  crms_pkg::crms_vid_t s2_r;
  crms_pkg::crms_vid_t s3_r;
  crms_pkg::crms_vid_t vid_r;
  crms_pkg::crms_vid_t main_nxt;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= crms_pkg::VID_RST;
      s2_r <= crms_pkg::VID_RST;
      s3_r <= crms_pkg::VID_RST;
    end else begin
      s1_r <= vid_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      vid_r <= crms_pkg::VID_RST;
    end else if (s2_r == s3_r) begin
      vid_r <= s3_r;
    end
  end

  assign vid_sync = vid_r;

  // ----------------------------------------------------------------
  // Caption replacement
  // ----------------------------------------------------------------
  // Host text wins over bridged text; both need a locked input
  always_comb begin
    main_nxt = vid_r;
    if (vid_r.locked && ins_text.valid) begin
      main_nxt.cc_valid = 1'b1;
      main_nxt.cc_data = ins_text.data;
    end else if (vid_r.locked && bridge_text.valid) begin
      main_nxt.cc_valid = 1'b1;
      main_nxt.cc_data = bridge_text.data;
      main_nxt.cc_std = bridge_std;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_main <= crms_pkg::VID_RST;
    end else begin
      out_main <= main_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_mon <= '0;
    end else begin
      out_mon.vid <= main_nxt;
      out_mon.ovl_valid <= main_nxt.cc_valid;
      out_mon.ovl_data <= main_nxt.cc_data;
    end
  end

endmodule : crms_chan
`default_nettype wire

// [hdl/crms_pkg.sv]
// Shared types and constants for the caption route and mode selector
package crms_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int SEL_W = 4;
  localparam int CC_W = 8;
  localparam int PIX_W = 10;
  localparam int STD_W = 2;

  // ----------------------------------------------------------------
  // Caption standards carried in a video word
  // ----------------------------------------------------------------
  localparam logic [STD_W-1:0] STD_608 = 2'h0;
  localparam logic [STD_W-1:0] STD_708 = 2'h1;
  localparam logic [STD_W-1:0] STD_OTHER = 2'h2;

  // ----------------------------------------------------------------
  // Route selector codes
  // ----------------------------------------------------------------
  localparam logic [SEL_W-1:0] RT_ENC_LAST = 4'h2;
  localparam logic [SEL_W-1:0] RT_BOTH_LAST = 4'h7;
  localparam logic [SEL_W-1:0] RT_DEC_A = 4'h8;
  localparam logic [SEL_W-1:0] RT_DEC_B = 4'h9;

  // ----------------------------------------------------------------
  // Bridge selector codes
  // ----------------------------------------------------------------
  localparam logic [SEL_W-1:0] BR_AB_BOTH = 4'h1;
  localparam logic [SEL_W-1:0] BR_BA_BOTH = 4'h2;
  localparam logic [SEL_W-1:0] BR_AB_F1 = 4'h3;
  localparam logic [SEL_W-1:0] BR_BA_F1 = 4'h4;
  localparam logic [SEL_W-1:0] BR_AB_F2 = 4'h5;
  localparam logic [SEL_W-1:0] BR_BA_F2 = 4'h6;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CLS_ENC  = 4'b0001,
    CLS_BOTH = 4'b0010,
    CLS_DEC  = 4'b0100,
    CLS_NONE = 4'b1000
  } crms_class_t;

  typedef enum logic [2:0] {
    SRC_OFF = 3'b001,
    SRC_SER = 3'b010,
    SRC_NET = 3'b100
  } crms_src_t;

  typedef struct packed {
    logic locked;
    logic field2;
    logic hd;
    logic [STD_W-1:0] cc_std;
    logic cc_valid;
    logic [CC_W-1:0] cc_data;
    logic [PIX_W-1:0] pix;
  } crms_vid_t;

  typedef struct packed {
    crms_vid_t vid;
    logic ovl_valid;
    logic [CC_W-1:0] ovl_data;
  } crms_mon_t;

  typedef struct packed {
    logic valid;
    logic [CC_W-1:0] data;
  } crms_text_t;

  typedef struct packed {
    crms_class_t cls;
    crms_src_t src_a;
    crms_src_t src_b;
    logic dec_a_ser;
    logic dec_a_net;
    logic dec_b_ser;
    logic dec_b_net;
  } crms_route_t;

  localparam crms_vid_t VID_RST = '0;

endpackage : crms_pkg

// [hdl/crms_top.sv]
// Caption route and mode selector: two channels, two selectors, two links
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Bridge selector: 0 none; 1,2 both fields; 3,4 field 1; 5,6 field 2.
// - Route selector 0-2 encode, 3-7 encode and decode, 8-9 decode.
// - Encode-only: 0 A serial B network; 1 both serial; 2 both network.
// - Input one feeds odd outputs, input two feeds even outputs.
// - Outputs three and four show captions of outputs one and two.
// - Decoded text goes to the host link; video captions stay unchanged.
// - A to B bridging copies A captions into B; A keeps its own.
// - Bridging across differing formats converts only 608/708 captions.
// - While locked, host text is inserted the cycle it arrives.
// - Channels run independently; inputs need not be synchronous.
// - Bridging is set by the bridge selector alone; valid host text on a channel wins over bridged text.
// - Route 8 decodes input one, 9 input two, to both links.
module crms_top (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [crms_pkg::SEL_W-1:0] route_selector,
  input wire logic [crms_pkg::SEL_W-1:0] bridge_selector,
  input wire crms_pkg::crms_vid_t vid_in_a,
  input wire crms_pkg::crms_vid_t vid_in_b,
  input wire crms_pkg::crms_text_t ser_rx,
  input wire crms_pkg::crms_text_t net_rx,
  output crms_pkg::crms_vid_t vid_out_1,
  output crms_pkg::crms_vid_t vid_out_2,
  output crms_pkg::crms_mon_t burned_in_overlay_3,
  output crms_pkg::crms_mon_t burned_in_overlay_4,
  output crms_pkg::crms_text_t ser_tx,
  output crms_pkg::crms_text_t net_tx
);

  // ----------------------------------------------------------------
  // Selector synchronisers
  // ----------------------------------------------------------------
  // Rotary switches are pins; a setting is taken once it holds still
  logic [crms_pkg::SEL_W-1:0] rs1_r;
  logic [crms_pkg::SEL_W-1:0] rs2_r;
  logic [crms_pkg::SEL_W-1:0] rs3_r;
  logic [crms_pkg::SEL_W-1:0] route_r;
  logic [crms_pkg::SEL_W-1:0] bs1_r;
  logic [crms_pkg::SEL_W-1:0] bs2_r;
  logic [crms_pkg::SEL_W-1:0] bs3_r;
  logic [crms_pkg::SEL_W-1:0] bridge_r;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rs1_r <= 4'hF;
      rs2_r <= 4'hF;
      rs3_r <= 4'hF;
      route_r <= 4'hF;
    end else begin
      rs1_r <= route_selector;
      rs2_r <= rs1_r;
      rs3_r <= rs2_r;
      if (rs2_r == rs3_r) begin
        route_r <= rs3_r;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bs1_r <= 4'h0;
      bs2_r <= 4'h0;
      bs3_r <= 4'h0;
      bridge_r <= 4'h0;
    end else begin
      bs1_r <= bridge_selector;
      bs2_r <= bs1_r;
      bs3_r <= bs2_r;
      if (bs2_r == bs3_r) begin
        bridge_r <= bs3_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Route decode
  // ----------------------------------------------------------------
  function automatic crms_pkg::crms_route_t route_of(
    input logic [crms_pkg::SEL_W-1:0] sel
  );
    crms_pkg::crms_route_t r;
    r = '{cls: crms_pkg::CLS_NONE, src_a: crms_pkg::SRC_OFF,
          src_b: crms_pkg::SRC_OFF, default: 1'b0};
    if (sel <= crms_pkg::RT_ENC_LAST) begin
      r.cls = crms_pkg::CLS_ENC;
    end else if (sel <= crms_pkg::RT_BOTH_LAST) begin
      r.cls = crms_pkg::CLS_BOTH;
    end else if (sel <= crms_pkg::RT_DEC_B) begin
      r.cls = crms_pkg::CLS_DEC;
    end
    case (sel)
      4'h0: begin
        r.src_a = crms_pkg::SRC_SER;
        r.src_b = crms_pkg::SRC_NET;
      end
      4'h1: begin
        r.src_a = crms_pkg::SRC_SER;
        r.src_b = crms_pkg::SRC_SER;
      end
      4'h2: begin
        r.src_a = crms_pkg::SRC_NET;
        r.src_b = crms_pkg::SRC_NET;
      end
      4'h3: begin
        r.src_a = crms_pkg::SRC_SER;
        r.src_b = crms_pkg::SRC_NET;
        r.dec_a_ser = 1'b1;
        r.dec_b_net = 1'b1;
      end
      4'h4: begin
        r.src_a = crms_pkg::SRC_SER;
        r.src_b = crms_pkg::SRC_SER;
        r.dec_a_ser = 1'b1;
        r.dec_a_net = 1'b1;
      end
      4'h5: begin
        r.src_a = crms_pkg::SRC_NET;
        r.src_b = crms_pkg::SRC_NET;
        r.dec_b_ser = 1'b1;
        r.dec_b_net = 1'b1;
      end
      4'h6: begin
        r.src_a = crms_pkg::SRC_SER;
        r.src_b = crms_pkg::SRC_SER;
        r.dec_b_ser = 1'b1;
        r.dec_b_net = 1'b1;
      end
      4'h7: begin
        r.src_a = crms_pkg::SRC_NET;
        r.src_b = crms_pkg::SRC_NET;
        r.dec_a_ser = 1'b1;
        r.dec_a_net = 1'b1;
      end
      crms_pkg::RT_DEC_A: begin
        r.dec_a_ser = 1'b1;
        r.dec_a_net = 1'b1;
      end
      crms_pkg::RT_DEC_B: begin
        r.dec_b_ser = 1'b1;
        r.dec_b_net = 1'b1;
      end
      default: begin
        r.cls = crms_pkg::CLS_NONE;
      end
    endcase
    return r;
  endfunction : route_of

  crms_pkg::crms_route_t route;
  assign route = route_of(route_r);

  function automatic crms_pkg::crms_text_t pick(
    input crms_pkg::crms_src_t src,
    input crms_pkg::crms_text_t ser,
    input crms_pkg::crms_text_t net
  );
    crms_pkg::crms_text_t t;
    t = '0;
    if (src == crms_pkg::SRC_SER) begin
      t = ser;
    end else if (src == crms_pkg::SRC_NET) begin
      t = net;
    end
    return t;
  endfunction : pick

  // ----------------------------------------------------------------
  // Bridge decode
  // ----------------------------------------------------------------
  // Host links are not consulted here, so bridging runs unattended
  logic br_ab;
  logic br_ba;
  logic br_f1;
  logic br_f2;

  always_comb begin
    br_ab = bridge_r inside {crms_pkg::BR_AB_BOTH, crms_pkg::BR_AB_F1,
                             crms_pkg::BR_AB_F2};
    br_ba = bridge_r inside {crms_pkg::BR_BA_BOTH, crms_pkg::BR_BA_F1,
                             crms_pkg::BR_BA_F2};
    br_f1 = bridge_r inside {crms_pkg::BR_AB_BOTH, crms_pkg::BR_BA_BOTH,
                             crms_pkg::BR_AB_F1, crms_pkg::BR_BA_F1};
    br_f2 = bridge_r inside {crms_pkg::BR_AB_BOTH, crms_pkg::BR_BA_BOTH,
                             crms_pkg::BR_AB_F2, crms_pkg::BR_BA_F2};
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  crms_pkg::crms_vid_t sync_a;
  crms_pkg::crms_vid_t sync_b;
  crms_pkg::crms_text_t ins_a;
  crms_pkg::crms_text_t ins_b;
  crms_pkg::crms_text_t brg_a;
  crms_pkg::crms_text_t brg_b;
  logic [crms_pkg::STD_W-1:0] std_a;
  logic [crms_pkg::STD_W-1:0] std_b;

  // Source caption may cross formats only if it is 608 or 708
  function automatic logic conv_ok(
    input crms_pkg::crms_vid_t src,
    input crms_pkg::crms_vid_t dst
  );
    return (src.hd == dst.hd) || (src.cc_std == crms_pkg::STD_608) ||
           (src.cc_std == crms_pkg::STD_708);
  endfunction : conv_ok
  function automatic logic [crms_pkg::STD_W-1:0] conv_std(
    input crms_pkg::crms_vid_t src,
    input crms_pkg::crms_vid_t dst
  );
    logic [crms_pkg::STD_W-1:0] s;
    s = src.cc_std;
    if (src.hd != dst.hd) begin
      s = dst.hd ? crms_pkg::STD_708 : crms_pkg::STD_608;
    end
    return s;
  endfunction : conv_std

  always_comb begin
    ins_a = pick(route.src_a, ser_rx, net_rx);
    ins_b = pick(route.src_b, ser_rx, net_rx);
    if (route.cls inside {crms_pkg::CLS_DEC, crms_pkg::CLS_NONE}) begin
      ins_a = '0;
      ins_b = '0;
    end
  end

  always_comb begin
    brg_b.valid = br_ab && sync_a.cc_valid && conv_ok(sync_a, sync_b) &&
                  (sync_a.field2 ? br_f2 : br_f1);
    brg_b.data = sync_a.cc_data;
    std_b = conv_std(sync_a, sync_b);
    brg_a.valid = br_ba && sync_b.cc_valid && conv_ok(sync_b, sync_a) &&
                  (sync_b.field2 ? br_f2 : br_f1);
    brg_a.data = sync_b.cc_data;
    std_a = conv_std(sync_b, sync_a);
  end

  crms_chan u_chan_a (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .vid_pin(vid_in_a),
    .ins_text(ins_a),
    .bridge_text(brg_a),
    .bridge_std(std_a),
    .vid_sync(sync_a),
    .out_main(vid_out_1),
    .out_mon(burned_in_overlay_3)
  );

  crms_chan u_chan_b (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .vid_pin(vid_in_b),
    .ins_text(ins_b),
    .bridge_text(brg_b),
    .bridge_std(std_b),
    .vid_sync(sync_b),
    .out_main(vid_out_2),
    .out_mon(burned_in_overlay_4)
  );

  // ----------------------------------------------------------------
  // Decoded text to host links
  // ----------------------------------------------------------------
  // Text is read from the input word; the video word is left alone
  crms_pkg::crms_text_t dec_a;
  crms_pkg::crms_text_t dec_b;
  assign dec_a = '{valid: sync_a.cc_valid, data: sync_a.cc_data};
  assign dec_b = '{valid: sync_b.cc_valid, data: sync_b.cc_data};

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ser_tx <= '0;
    end else if (route.dec_a_ser) begin
      ser_tx <= dec_a;
    end else if (route.dec_b_ser) begin
      ser_tx <= dec_b;
    end else begin
      ser_tx <= '0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      net_tx <= '0;
    end else if (route.dec_a_net) begin
      net_tx <= dec_a;
    end else if (route.dec_b_net) begin
      net_tx <= dec_b;
    end else begin
      net_tx <= '0;
    end
  end

endmodule : crms_top
`default_nettype wire

// [tb/crms_host.sv]
// Host model sending caption text bytes on both links
`timescale 1ns/1ps
`default_nettype none
module crms_host (
  input wire logic sys_clk,
  output var crms_pkg::crms_text_t ser_rx,
  output var crms_pkg::crms_text_t net_rx
);
  initial begin
    ser_rx = '0;
    net_rx = '0;
  end
  // One-cycle byte; idle data is inverted so stale bytes never match
  task automatic send(input logic to_net, input logic [7:0] d);
    @(posedge sys_clk);
    if (to_net) net_rx <= {1'b1, d};
    else ser_rx <= {1'b1, d};
    @(posedge sys_clk);
    ser_rx <= {1'b0, ~d};
    net_rx <= {1'b0, ~d};
  endtask : send
endmodule : crms_host
`default_nettype wire

// [tb/crms_test.sv]
// Self-checking bench for the caption route and mode selector
`timescale 1ns/1ps
`default_nettype none
module caption_route_mode_select_test;
  // ----------
  // Maps, one bit per route value
  // ----------
  localparam logic [15:0] SER_A = 16'h0198;
  localparam logic [15:0] SER_B = 16'h0260;
  localparam logic [15:0] NET_A = 16'h0190;
  localparam logic [15:0] NET_B = 16'h0268;
  localparam logic [15:0] INS_AS = 16'h005B;
  localparam logic [15:0] INS_BS = 16'h0052;
  localparam logic [15:0] INS_AN = 16'h00A4;
  localparam logic [15:0] INS_BN = 16'h00AD;
  logic sys_clk;
  logic arst_n;
  logic [3:0] route_selector;
  logic [3:0] bridge_selector;
  crms_pkg::crms_vid_t vid_in_a;
  crms_pkg::crms_vid_t vid_in_b;
  crms_pkg::crms_vid_t vid_out_1;
  crms_pkg::crms_vid_t vid_out_2;
  crms_pkg::crms_mon_t burned_in_overlay_3;
  crms_pkg::crms_mon_t burned_in_overlay_4;
  crms_pkg::crms_text_t ser_rx;
  crms_pkg::crms_text_t net_rx;
  crms_pkg::crms_text_t ser_tx;
  crms_pkg::crms_text_t net_tx;
  int n_errors;
  int tests_run;
  crms_top i_dut (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .route_selector(route_selector),
    .bridge_selector(bridge_selector),
    .vid_in_a(vid_in_a),
    .vid_in_b(vid_in_b),
    .ser_rx(ser_rx),
    .net_rx(net_rx),
    .vid_out_1(vid_out_1),
    .vid_out_2(vid_out_2),
    .burned_in_overlay_3(burned_in_overlay_3),
    .burned_in_overlay_4(burned_in_overlay_4),
    .ser_tx(ser_tx),
    .net_tx(net_tx)
  );
  crms_host i_host (.sys_clk(sys_clk), .ser_rx(ser_rx), .net_rx(net_rx));
  // ----------
  // Helpers
  // ----------
  task automatic chk(input string what, input logic [63:0] exp,
      input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  function automatic crms_pkg::crms_vid_t mk(input logic lk, input logic f2,
      input logic hd, input logic [1:0] sd, input logic [7:0] cc);
    return {lk, f2, hd, sd, 1'b1, cc, cc, 2'h1};
  endfunction : mk
  // Nine edges: sync, accept and output, plus margin for the checker
  task automatic setup(input logic [3:0] r, input logic [3:0] b,
      input crms_pkg::crms_vid_t wa, input crms_pkg::crms_vid_t wb);
    @(posedge sys_clk);
    route_selector <= r;
    bridge_selector <= b;
    vid_in_a <= wa;
    vid_in_b <= wb;
    repeat (9) @(posedge sys_clk);
    #1;
  endtask : setup
  task automatic stop_test();
    $display("Checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  // ----------
  // Scenarios
  // ----------
  task automatic t_routes();
    crms_pkg::crms_vid_t wa;
    crms_pkg::crms_vid_t wb;
    logic [8:0] es;
    logic [8:0] en;
    wa = mk(1'b1, 1'b0, 1'b0, crms_pkg::STD_608, 8'hA1);
    wb = mk(1'b1, 1'b0, 1'b0, crms_pkg::STD_608, 8'hB2);
    for (int r = 0; r < 16; r++) begin
      setup(4'(r), 4'h0, wa, wb);
      es = SER_A[r] ? 9'h1A1 : SER_B[r] ? 9'h1B2 : 9'h000;
      en = NET_A[r] ? 9'h1A1 : NET_B[r] ? 9'h1B2 : 9'h000;
      chk("ser_tx", es, ser_tx);
      chk("net_tx", en, net_tx);
      chk("vid_out_1", wa, vid_out_1);
      chk("vid_out_2", wb, vid_out_2);
      i_host.send(1'b0, 8'h5C);
      #1;
      chk("ins_1", INS_AS[r] ? 8'h5C : 8'hA1, vid_out_1.cc_data);
      chk("ins_2", INS_BS[r] ? 8'h5C : 8'hB2, vid_out_2.cc_data);
      i_host.send(1'b1, 8'hE7);
      #1;
      chk("ins_1", INS_AN[r] ? 8'hE7 : 8'hA1, vid_out_1.cc_data);
      chk("ins_2", INS_BN[r] ? 8'hE7 : 8'hB2, vid_out_2.cc_data);
    end
  endtask : t_routes
  task automatic t_bridge();
    logic [3:0] b;
    logic f;
    logic ab;
    logic ba;
    for (int i = 0; i < 32; i++) begin
      b = 4'(i);
      f = i[4];
      ab = b == 4'h1 || b == (f ? 4'h5 : 4'h3);
      ba = b == 4'h2 || b == (f ? 4'h6 : 4'h4);
      setup(4'hF, b, mk(1'b1, f, 1'b0, crms_pkg::STD_608, 8'hA1),
          mk(1'b1, f, 1'b0, crms_pkg::STD_608, 8'hB2));
      chk("bridge_2", ab ? 8'hA1 : 8'hB2, vid_out_2.cc_data);
      chk("bridge_1", ba ? 8'hB2 : 8'hA1, vid_out_1.cc_data);
    end
  endtask : t_bridge
  task automatic t_xfmt();
    crms_pkg::crms_vid_t wb;
    wb = mk(1'b1, 1'b0, 1'b0, crms_pkg::STD_608, 8'hB2);
    setup(4'hF, 4'h1, mk(1'b1, 1'b0, 1'b1, crms_pkg::STD_708, 8'hA1), wb);
    chk("xfmt_cc", 8'hA1, vid_out_2.cc_data);
    chk("xfmt_std", crms_pkg::STD_608, vid_out_2.cc_std);
    setup(4'hF, 4'h1, mk(1'b1, 1'b0, 1'b1, crms_pkg::STD_OTHER, 8'hA1), wb);
    chk("xfmt_other", wb, vid_out_2);
    setup(4'hF, 4'h2, mk(1'b1, 1'b0, 1'b1, crms_pkg::STD_608, 8'hA1), wb);
    chk("xfmt_hd_cc", 8'hB2, vid_out_1.cc_data);
    chk("xfmt_hd_std", crms_pkg::STD_708, vid_out_1.cc_std);
  endtask : t_xfmt
  task automatic t_unlock();
    setup(4'h1, 4'h0, mk(1'b0, 1'b0, 1'b0, crms_pkg::STD_608, 8'hA1),
        mk(1'b1, 1'b0, 1'b0, crms_pkg::STD_608, 8'hB2));
    i_host.send(1'b0, 8'h5C);
    #1;
    chk("unlocked", 8'hA1, vid_out_1.cc_data);
    chk("locked", 8'h5C, vid_out_2.cc_data);
  endtask : t_unlock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    stop_test();
  end
  initial begin
    n_errors = 0;
    tests_run = 0;
    arst_n = 1'b0;
    route_selector = 4'h0;
    bridge_selector = 4'h0;
    vid_in_a = crms_pkg::VID_RST;
    vid_in_b = crms_pkg::VID_RST;
    repeat (15) @(posedge sys_clk);
    #1;
    chk("reset_out", 64'h0, {vid_out_1, vid_out_2, ser_tx});
    chk("reset_mon", 64'h0, {burned_in_overlay_4, net_tx});
    chk("reset_ovl", 64'h0, burned_in_overlay_3);
    @(posedge sys_clk);
    arst_n <= 1'b1;
    t_routes();
    t_bridge();
    t_xfmt();
    t_unlock();
    stop_test();
  end
endmodule : caption_route_mode_select_test
`default_nettype wire

// [tb/crms_top_assertions.sv]
// Port checks for the caption route and mode selector
`timescale 1ns/1ps
`default_nettype none
module crms_chk (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [crms_pkg::SEL_W-1:0] route_selector,
  input wire logic [crms_pkg::SEL_W-1:0] bridge_selector,
  input wire crms_pkg::crms_vid_t vid_in_a,
  input wire crms_pkg::crms_vid_t vid_in_b,
  input wire crms_pkg::crms_text_t ser_rx,
  input wire crms_pkg::crms_vid_t vid_out_1,
  input wire crms_pkg::crms_vid_t vid_out_2,
  input wire crms_pkg::crms_mon_t burned_in_overlay_3,
  input wire crms_pkg::crms_mon_t burned_in_overlay_4,
  input wire crms_pkg::crms_text_t ser_tx,
  input wire crms_pkg::crms_text_t net_tx
);
  // ----------
  // Settle counters
  // ----------
  // Pins cross a 3-stage sync, so only judge after 7 quiet edges
  logic [7:0] sel_now;
  logic [7:0] sel_r;
  logic [47:0] vid_now;
  logic [47:0] vid_r;
  logic [2:0] sel_cnt_r;
  logic [2:0] vid_cnt_r;
  logic sel_ok;
  logic vid_ok;
  assign sel_now = {route_selector, bridge_selector};
  assign vid_now = {vid_in_a, vid_in_b};
  assign sel_ok = sel_cnt_r == 3'h7 && sel_r == sel_now;
  assign vid_ok = sel_ok && vid_cnt_r == 3'h7 && vid_r == vid_now;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_r <= '0;
      sel_cnt_r <= 3'h0;
    end else begin
      sel_r <= sel_now;
      if (sel_r != sel_now) sel_cnt_r <= 3'h0;
      else if (sel_cnt_r != 3'h7) sel_cnt_r <= sel_cnt_r + 3'h1;
    end
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      vid_r <= '0;
      vid_cnt_r <= 3'h0;
    end else begin
      vid_r <= vid_now;
      if (vid_r != vid_now) vid_cnt_r <= 3'h0;
      else if (vid_cnt_r != 3'h7) vid_cnt_r <= vid_cnt_r + 3'h1;
    end
  end
  // ----------
  // Assertions
  // ----------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_ovl_video: assert property (
    burned_in_overlay_3.vid == vid_out_1 && burned_in_overlay_4.vid == vid_out_2)
    else $error("overlay video differs");
  a_ovl_text: assert property (
    {burned_in_overlay_3.ovl_valid, burned_in_overlay_3.ovl_data} ==
    {vid_out_1.cc_valid, vid_out_1.cc_data})
    else $error("overlay text differs");
  a_tx_quiet: assert property (
    sel_ok && !(route_selector inside {[4'h3:4'h9]})
    |-> !ser_tx.valid && !net_tx.valid)
    else $error("text sent while not decoding");
  a_dual_links: assert property (
    sel_ok && route_selector inside {[4'h4:4'h9]} |-> ser_tx == net_tx)
    else $error("links carry different text");
  a_pass_video: assert property (
    vid_ok && route_selector > 4'h7 && !(bridge_selector inside {[4'h1:4'h6]})
    |-> vid_out_1 == vid_in_a && vid_out_2 == vid_in_b)
    else $error("video altered");
  a_dec_text: assert property (
    vid_ok && route_selector == 4'h8 && vid_in_a.locked && vid_in_a.cc_valid
    |-> ser_tx == {1'b1, vid_in_a.cc_data})
    else $error("decoded text wrong");
  a_host_insert: assert property (
    vid_ok && route_selector == 4'h1 && vid_in_a.locked && ser_rx.valid
    |=> vid_out_1.cc_valid && vid_out_1.cc_data == $past(ser_rx.data))
    else $error("host byte not inserted");
  a_bridge_copy: assert property (
    vid_ok && route_selector > 4'h9 && bridge_selector == 4'h1 &&
    vid_in_a.locked && vid_in_b.locked && vid_in_a.hd == vid_in_b.hd &&
    vid_in_a.cc_valid |-> vid_out_2.cc_data == vid_in_a.cc_data &&
    vid_out_1 == vid_in_a)
    else $error("bridge copy wrong");
  c_decode: cover property (vid_ok && route_selector == 4'h8 && ser_tx.valid);
  c_insert: cover property (route_selector == 4'h1 && ser_rx.valid);
  c_bridge: cover property (vid_ok && bridge_selector == 4'h1);
endmodule : crms_chk
bind crms_top crms_chk i_chk (
  .sys_clk(sys_clk),
  .arst_n(arst_n),
  .route_selector(route_selector),
  .bridge_selector(bridge_selector),
  .vid_in_a(vid_in_a),
  .vid_in_b(vid_in_b),
  .ser_rx(ser_rx),
  .vid_out_1(vid_out_1),
  .vid_out_2(vid_out_2),
  .burned_in_overlay_3(burned_in_overlay_3),
  .burned_in_overlay_4(burned_in_overlay_4),
  .ser_tx(ser_tx),
  .net_tx(net_tx)
);
`default_nettype wire
